// ===== verilog/imusf_pkg.sv
/*
  imusf_pkg: shared constants of the imu sample fifo.
  assumes: register port 8-bit address and data.
*/
`default_nettype none
package imusf_pkg;
  // ==========================================================
  // register map
  localparam logic [7:0] ADDR_INT_CFG = 8'h02;
  localparam logic [7:0] ADDR_SENS_EN = 8'h08;
  localparam logic [7:0] ADDR_CMD = 8'h0a;
  localparam logic [7:0] ADDR_WTM = 8'h13;
  localparam logic [7:0] ADDR_FIFO_CTRL = 8'h14;
  localparam logic [7:0] ADDR_CNT = 8'h15;
  localparam logic [7:0] ADDR_STATUS = 8'h16;
  localparam logic [7:0] ADDR_POP = 8'h17;
  localparam logic [7:0] ADDR_SRST = 8'h60;
  // ==========================================================
  // codes and fields
  localparam logic [7:0] SRST_KEY = 8'hb0;
  localparam logic [7:0] CMD_DRAIN = 8'h05;
  localparam logic [7:0] CMD_FLUSH = 8'h04;
  localparam int INT_ROUTE_BIT = 2;
  localparam int INT_PP_A_BIT = 3;
  localparam int INT_PP_B_BIT = 4;
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_SIZE_LSB = 2;
  localparam int CTRL_DRAIN_BIT = 7;
  localparam int EN_ACC_BIT = 0;
  localparam int EN_GYR_BIT = 1;
  localparam int STAT_DRAIN_BIT = 5;
  localparam int STAT_FULL_BIT = 6;
  localparam int STAT_WTM_BIT = 7;
  localparam logic [1:0] MODE_BYPASS = 2'h0;
  localparam logic [1:0] MODE_STOP = 2'h1;
  localparam logic [1:0] MODE_STREAM = 2'h2;
  localparam logic [7:0] CAP_MIN = 8'h10;
  localparam logic [3:0] BYTES_ONE = 4'h6;
  localparam logic [3:0] BYTES_BOTH = 4'hc;
  localparam int SLOTS = 128;
  localparam int SLOT_W = 96;
  // ==========================================================
  // timing
  localparam int CLK_HZ = 50000000;
  localparam int SRST_TIME_MS = 15;
  localparam int SRST_CYC = SRST_TIME_MS * (CLK_HZ / 1000);
  typedef enum logic [1:0] {
    ST_RUN = 2'b01,
    ST_SRST = 2'b10
  } imusf_state_t;
endpackage
`default_nettype wire

// ===== verilog/imusf_sync.sv
/*
  imusf_sync: two-flop level synchroniser.
  assumes: d is quasi-static relative to clk.
*/
`timescale 1ns/100ps
`default_nettype none
module imusf_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] sync1_ff;

  // ==========================================================
  // first stage feeds only the second
  always_ff @(posedge clk) begin
    sync1_ff <= d;
    q <= sync1_ff;
  end
endmodule
`default_nettype wire

// ===== verilog/imusf_link_port.sv
/*
  imusf_link_port: link-clock side of the register port.
  assumes: core answers each request toggle with an ack toggle.
*/
`timescale 1ns/100ps
`default_nettype none
module imusf_link_port (
  input wire logic link_clk,
  input wire logic rst_n,
  input wire logic reg_req,
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic reg_ack,
  output logic [7:0] reg_rdata,
  output logic reg_busy,
  output logic req_tgl,
  output logic hold_wr,
  output logic [7:0] hold_addr,
  output logic [7:0] hold_wdata,
  input wire logic ack_tgl,
  input wire logic [7:0] core_rdata
);
  logic lrst_n;
  logic ack_s;
  logic ack_last_ff;
  logic take;

  imusf_sync #(.W(1)) u_rst (.clk(link_clk), .d(rst_n), .q(lrst_n));
  imusf_sync #(.W(1)) u_ack (.clk(link_clk), .d(ack_tgl), .q(ack_s));

  // a request still up in the ack cycle is the one just answered;
  // taking it again would repeat a pop or a command
  assign take = reg_req && !reg_busy && !reg_ack;

  // ==========================================================
  // request capture; held until ack so the core reads stable data
  always_ff @(posedge link_clk) begin
    if (!lrst_n) begin
      req_tgl <= 1'b0;
      hold_wr <= 1'b0;
      hold_addr <= 8'h00;
      hold_wdata <= 8'h00;
    end else if (take) begin
      req_tgl <= ~req_tgl;
      hold_wr <= reg_wr;
      hold_addr <= reg_addr;
      hold_wdata <= reg_wdata;
    end
  end

  // ==========================================================
  // answer side
  always_ff @(posedge link_clk) begin
    if (!lrst_n) begin
      reg_busy <= 1'b0;
      reg_ack <= 1'b0;
      reg_rdata <= 8'h00;
      ack_last_ff <= 1'b0;
    end else begin
      reg_ack <= 1'b0;
      if (ack_s != ack_last_ff) begin
        ack_last_ff <= ack_s;
        reg_busy <= 1'b0;
        reg_ack <= 1'b1;
        reg_rdata <= core_rdata;
      end else if (take) begin
        reg_busy <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ===== verilog/imusf_core.sv
/*
  imusf_core: imu sample fifo with register port, watermark
  and full flags, drain mode and two interrupt lines.
  assumes: samples arrive on clock as a one-cycle strobe;
  the register port runs on the host link clock.
*/
`timescale 1ns/100ps
`default_nettype none
// How it works
// - size code picks 16/32/64/128 samples
// - sample is 6 or 12 bytes
// - policy 0 bypass, 1 stop, 2 overwrite
// - store samples while buffering and sensor on
// - stop policy drops samples when full
// - overwrite policy drops oldest when full
// - 10-bit word count across two registers
// - nonzero watermark register enables watermark
// - watermark flag follows level versus watermark
// - bit 2 routes watermark to line a/b
// - bits 3,4 pick high-z or push-pull
// - push-pull irq drops after drain cleared
// - full flag when count equals capacity
// - drain command 0x05 opens pop port
// - samples discarded while draining
// - pop read returns oldest byte, removes it
// - writing drain bit 0 resumes filling
// - axis words low byte first, accel first
// - flush command empties the buffer
// - key 0xb0 at 0x60 soft-resets all but the link handshake
// - bypass policy gives data-ready pulses instead
module imusf_core import imusf_pkg::*; #(
  parameter int SRST_CYCLES = SRST_CYC
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic link_clk,
  input wire logic reg_req,
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic reg_ack,
  output logic [7:0] reg_rdata,
  output logic reg_busy,
  input wire logic sample_strobe,
  input wire logic [47:0] accel_data,
  input wire logic [47:0] gyro_data,
  output logic irq_line_a,
  output logic irq_line_a_oe_n,
  output logic irq_line_b,
  output logic irq_line_b_oe_n,
  output logic sample_ready_pulse
);
  // ==========================================================
  // capacity decode
  // size code to capacity
  function automatic logic [7:0] cap_of(input logic [1:0] sz);
    cap_of = CAP_MIN << sz;
  endfunction

  function automatic logic [6:0] ptr_inc(input logic [6:0] p, input logic [1:0] sz);
    logic [7:0] n;
    n = {1'b0, p} + 8'h01;
    ptr_inc = (n == cap_of(sz)) ? 7'h00 : n[6:0];
  endfunction

  // ==========================================================
  // link crossing
  logic req_tgl;
  logic hold_wr;
  logic [7:0] hold_addr;
  logic [7:0] hold_wdata;
  logic req_s;
  logic req_last_ff;
  logic ack_tgl_ff;
  logic [7:0] rdata_ff;
  logic req_seen;

  imusf_link_port u_link (
    .link_clk(link_clk),
    .rst_n(rst_n),
    .reg_req(reg_req),
    .reg_wr(reg_wr),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_ack(reg_ack),
    .reg_rdata(reg_rdata),
    .reg_busy(reg_busy),
    .req_tgl(req_tgl),
    .hold_wr(hold_wr),
    .hold_addr(hold_addr),
    .hold_wdata(hold_wdata),
    .ack_tgl(ack_tgl_ff),
    .core_rdata(rdata_ff)
  );

  imusf_sync #(.W(1)) u_req (.clk(clock), .d(req_tgl), .q(req_s));

  assign req_seen = req_s ^ req_last_ff;

  // ==========================================================
  // state and registers
  imusf_state_t st_ff;
  logic [19:0] srst_cnt_ff;
  logic clr;
  logic [7:0] int_cfg_ff;
  logic [1:0] sens_en_ff;
  logic [7:0] wtm_ff;
  logic [1:0] mode_ff;
  logic [1:0] size_ff;
  logic drain_ff;
  logic [SLOT_W-1:0] mem [SLOTS];
  logic [6:0] wr_ptr_ff;
  logic [6:0] rd_ptr_ff;
  logic [7:0] cnt_ff;
  logic [3:0] rd_off_ff;
  logic full_ff;
  logic wtm_flag_ff;
  logic wtm_irq_ff;

  logic wr_hit;
  logic rd_hit;
  logic buffering;
  logic any_sens;
  logic [3:0] bps;
  logic [7:0] cap;
  logic full_now;
  logic push;
  logic drop_old;
  logic pop;
  logic flush;
  logic [10:0] byte_cnt;
  logic [9:0] word_cnt;
  logic [SLOT_W-1:0] slot_in;
  logic [SLOT_W-1:0] head;
  logic [7:0] pop_byte;

  assign clr = !rst_n || (st_ff == ST_SRST);
  assign wr_hit = req_seen && hold_wr && (st_ff == ST_RUN);
  assign rd_hit = req_seen && !hold_wr && (st_ff == ST_RUN);
  assign buffering = (mode_ff == MODE_STOP) || (mode_ff == MODE_STREAM);
  assign any_sens = |sens_en_ff;
  assign bps = (&sens_en_ff) ? BYTES_BOTH : BYTES_ONE;
  assign cap = cap_of(size_ff);
  assign full_now = (cnt_ff == cap);
  assign push = sample_strobe && buffering && any_sens && !drain_ff
    && (!full_now || (mode_ff == MODE_STREAM));
  assign drop_old = push && full_now;
  // pop read only in drain mode
  assign pop = rd_hit && (hold_addr == ADDR_POP) && drain_ff && (cnt_ff != 8'h00);
  assign flush = wr_hit && (hold_addr == ADDR_CMD) && (hold_wdata == CMD_FLUSH);
  // word count is the byte count halved, rounded down
  assign byte_cnt = 11'(cnt_ff) * 11'(bps) - 11'(rd_off_ff);
  assign word_cnt = byte_cnt[10:1];
  assign head = mem[rd_ptr_ff];
  assign pop_byte = head[{rd_off_ff, 3'h0} +: 8];

  // x,y,z words little-endian, accel before gyro
  always_comb begin
    slot_in = {48'h0, accel_data};
    if (&sens_en_ff) begin
      slot_in = {gyro_data, accel_data};
    end else if (sens_en_ff[EN_GYR_BIT]) begin
      slot_in = {48'h0, gyro_data};
    end
  end

  // ==========================================================
  // soft reset sequencer
  // key write starts reset, held for the boot time
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      st_ff <= ST_RUN;
      srst_cnt_ff <= 20'h00000;
    end else begin
      case (st_ff)
        ST_RUN: begin
          if (wr_hit && hold_addr == ADDR_SRST && hold_wdata == SRST_KEY) begin
            st_ff <= ST_SRST;
            srst_cnt_ff <= 20'(SRST_CYCLES - 1);
          end
        end
        ST_SRST: begin
          if (srst_cnt_ff == 20'h00000) begin
            st_ff <= ST_RUN;
          end else begin
            srst_cnt_ff <= srst_cnt_ff - 20'h00001;
          end
        end
        default: begin
          st_ff <= ST_RUN;
        end
      endcase
    end
  end

  // ==========================================================
  // handshake back to the link side
  // toggles survive soft reset so the link never desyncs
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      req_last_ff <= 1'b0;
      ack_tgl_ff <= 1'b0;
    end else if (req_seen) begin
      req_last_ff <= req_s;
      ack_tgl_ff <= ~ack_tgl_ff;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rdata_ff <= 8'h00;
    end else if (rd_hit) begin
      case (hold_addr)
        ADDR_INT_CFG: rdata_ff <= int_cfg_ff;
        ADDR_SENS_EN: rdata_ff <= {6'h00, sens_en_ff};
        ADDR_WTM: rdata_ff <= wtm_ff;
        ADDR_FIFO_CTRL: begin
          rdata_ff <= {drain_ff, 3'h0, size_ff, mode_ff};
        end
        ADDR_CNT: rdata_ff <= word_cnt[7:0];
        ADDR_STATUS: begin
          rdata_ff <= {wtm_flag_ff, full_ff, drain_ff, 3'h0, word_cnt[9:8]};
        end
        ADDR_POP: rdata_ff <= pop ? pop_byte : 8'h00;
        default: rdata_ff <= 8'h00;
      endcase
    end else if (req_seen) begin
      rdata_ff <= 8'h00;
    end
  end

  // ==========================================================
  // configuration registers
  // watermark register at its offset
  always_ff @(posedge clock) begin
    if (clr) begin
      int_cfg_ff <= 8'h00;
      sens_en_ff <= 2'h0;
      wtm_ff <= 8'h00;
      mode_ff <= MODE_BYPASS;
      size_ff <= 2'h0;
    end else if (wr_hit) begin
      case (hold_addr)
        ADDR_INT_CFG: int_cfg_ff <= hold_wdata;
        ADDR_SENS_EN: sens_en_ff <= hold_wdata[EN_GYR_BIT:EN_ACC_BIT];
        ADDR_WTM: wtm_ff <= hold_wdata;
        ADDR_FIFO_CTRL: begin
          mode_ff <= hold_wdata[CTRL_MODE_LSB +: 2];
          size_ff <= hold_wdata[CTRL_SIZE_LSB +: 2];
        end
        default: begin
        end
      endcase
    end
  end

  // writing drain bit 0 clears it
  always_ff @(posedge clock) begin
    if (clr) begin
      drain_ff <= 1'b0;
    end else if (wr_hit && hold_addr == ADDR_CMD && hold_wdata == CMD_DRAIN) begin
      drain_ff <= 1'b1;
    end else if (wr_hit && hold_addr == ADDR_FIFO_CTRL) begin
      drain_ff <= hold_wdata[CTRL_DRAIN_BIT];
    end
  end

  // ==========================================================
  // sample storage; a whole sample per slot
  always_ff @(posedge clock) begin
    if (push) begin
      mem[wr_ptr_ff] <= slot_in;
    end
  end

  // push and pop never meet: push needs drain off, pop needs it on
  always_ff @(posedge clock) begin
    if (clr || flush) begin
      wr_ptr_ff <= 7'h00;
      rd_ptr_ff <= 7'h00;
      cnt_ff <= 8'h00;
      rd_off_ff <= 4'h0;
    end else if (push) begin
      wr_ptr_ff <= ptr_inc(wr_ptr_ff, size_ff);
      if (drop_old) begin
        rd_ptr_ff <= ptr_inc(rd_ptr_ff, size_ff);
        rd_off_ff <= 4'h0;
      end else begin
        cnt_ff <= cnt_ff + 8'h01;
      end
    end else if (pop) begin
      if (rd_off_ff + 4'h1 >= bps) begin
        rd_off_ff <= 4'h0;
        rd_ptr_ff <= ptr_inc(rd_ptr_ff, size_ff);
        cnt_ff <= cnt_ff - 8'h01;
      end else begin
        rd_off_ff <= rd_off_ff + 4'h1;
      end
    end
  end

  // ==========================================================
  // flags
  always_ff @(posedge clock) begin
    if (clr) begin
      full_ff <= 1'b0;
      wtm_flag_ff <= 1'b0;
      wtm_irq_ff <= 1'b0;
    end else begin
      full_ff <= full_now;
      wtm_flag_ff <= (wtm_ff != 8'h00) && (cnt_ff >= wtm_ff);
      // held until drained and drain mode off
      if ((wtm_ff != 8'h00) && (cnt_ff >= wtm_ff)) begin
        wtm_irq_ff <= 1'b1;
      end else if (!drain_ff) begin
        wtm_irq_ff <= 1'b0;
      end
    end
  end

  // bypass gives a data-ready pulse per sample
  always_ff @(posedge clock) begin
    if (clr) begin
      sample_ready_pulse <= 1'b0;
    end else begin
      sample_ready_pulse <= sample_strobe && (mode_ff == MODE_BYPASS) && any_sens;
    end
  end

  // ==========================================================
  // interrupt lines; oe_n low while driving
  logic [1:0] line_q;
  logic [1:0] line_oe_n;

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_line
      logic to_me;
      logic push_pull;
      logic rdy;
      assign to_me = (gi == 0) ? int_cfg_ff[INT_ROUTE_BIT] : !int_cfg_ff[INT_ROUTE_BIT];
      assign push_pull = int_cfg_ff[INT_PP_A_BIT + gi];
      assign rdy = (gi == 1) && (mode_ff == MODE_BYPASS) && any_sens
        && sample_strobe;
      always_ff @(posedge clock) begin
        if (clr) begin
          line_q[gi] <= 1'b0;
          line_oe_n[gi] <= 1'b1;
        end else begin
          line_q[gi] <= (to_me && buffering && wtm_irq_ff) || rdy;
          line_oe_n[gi] <= !push_pull;
        end
      end
    end
  endgenerate

  assign irq_line_a = line_q[0];
  assign irq_line_a_oe_n = line_oe_n[0];
  assign irq_line_b = line_q[1];
  assign irq_line_b_oe_n = line_oe_n[1];
endmodule
`default_nettype wire

// ===== test/imusf_core_assertions.sv
/*
  imusf_core_assertions: port checks of imusf_core.
  assumes: bound into every imusf_core instance.
*/
`timescale 1ns/100ps
`default_nettype none
module imusf_core_assertions (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic link_clk,
  input wire logic reg_req,
  input wire logic reg_ack,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_busy,
  input wire logic sample_strobe,
  input wire logic irq_line_a,
  input wire logic irq_line_a_oe_n,
  input wire logic irq_line_b,
  input wire logic irq_line_b_oe_n,
  input wire logic sample_ready_pulse
);
  // ==========
  // register port
  sequence s_take;
    reg_req && !reg_busy && !reg_ack;
  endsequence
  sequence s_answer;
    ##[3:10] reg_ack;
  endsequence
  a_take_busy: assert property (
    @(posedge link_clk) disable iff (!rst_n) s_take |=> reg_busy)
    else $error("request taken without busy");
  a_ack_bounded: assert property (
    @(posedge link_clk) disable iff (!rst_n) s_take |-> s_answer)
    else $error("no answer in time");
  a_ack_single: assert property (
    @(posedge link_clk) disable iff (!rst_n) reg_ack |=> !reg_ack)
    else $error("ack longer than one cycle");
  a_ack_not_busy: assert property (
    @(posedge link_clk) disable iff (!rst_n) reg_ack |-> !reg_busy)
    else $error("busy during ack");
  a_busy_ends_ack: assert property (
    @(posedge link_clk) disable iff (!rst_n) $fell(reg_busy) |-> reg_ack)
    else $error("busy dropped without ack");
  a_rdata_holds: assert property (
    @(posedge link_clk) disable iff (!rst_n) $changed(reg_rdata) |-> reg_ack)
    else $error("read data moved outside ack");
  // ==========
  // core side
  a_ready_cause: assert property (
    @(posedge clock) disable iff (!rst_n) sample_ready_pulse |-> $past(sample_strobe))
    else $error("ready pulse without strobe");
  a_reset_quiet: assert property (
    @(posedge clock) !rst_n |=> !irq_line_a && !irq_line_b && !sample_ready_pulse
      && irq_line_a_oe_n && irq_line_b_oe_n)
    else $error("outputs active after reset");
endmodule
bind imusf_core imusf_core_assertions u_chk (.clock, .rst_n, .link_clk, .reg_req,
  .reg_ack, .reg_rdata, .reg_busy, .sample_strobe, .irq_line_a, .irq_line_a_oe_n,
  .irq_line_b, .irq_line_b_oe_n, .sample_ready_pulse);
`default_nettype wire

// ===== test/imusf_host_model.sv
/*
  imusf_host_model: host master of the register port.
  assumes: free-running link_clk from the bench.
*/
`timescale 1ns/100ps
`default_nettype none
module imusf_host_model (
  input wire logic link_clk,
  output logic reg_req,
  output logic reg_wr,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  input wire logic reg_ack,
  input wire logic [7:0] reg_rdata
);
  int n_lost = 0;
  initial begin
    reg_req = 1'b0;
    reg_wr = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end
  task automatic xfer(input logic wr, input logic [7:0] a, d, output logic [7:0] q);
    int k;
    k = 0;
    @(negedge link_clk);
    reg_req = 1'b1;
    reg_wr = wr;
    reg_addr = a;
    reg_wdata = d;
    do begin
      @(posedge link_clk);
      k++;
    end while (reg_ack !== 1'b1 && k < 40);
    q = reg_rdata;
    if (reg_ack !== 1'b1) n_lost++;
    @(negedge link_clk);
    reg_req = 1'b0;
    // released lines show no stale value
    reg_wr = ~wr;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask
endmodule
`default_nettype wire

// ===== test/testbench.sv
/*
  testbench: self-checking bench of imusf_core.
  assumes: host model drives the register port.
*/
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) chk(16'(a), 16'(e))
module testbench import imusf_pkg::*;;
  logic clock = 1'b0, link_clk = 1'b0, rst_n = 1'b0, sample_strobe = 1'b0;
  logic [47:0] accel_data = '0, gyro_data = '0;
  logic reg_req, reg_wr, reg_ack, reg_busy, sample_ready_pulse;
  logic irq_line_a, irq_line_a_oe_n, irq_line_b, irq_line_b_oe_n;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, q;
  int n_fail = 0, n_tests = 0, cyc = 0, n_smp = 0;
  initial forever #10 clock = ~clock;
  initial begin
    #7;
    forever #24 link_clk = ~link_clk;
  end
  imusf_core #(.SRST_CYCLES(20)) u_dut (.clock, .rst_n, .link_clk, .reg_req, .reg_wr,
    .reg_addr, .reg_wdata, .reg_ack, .reg_rdata, .reg_busy, .sample_strobe, .accel_data,
    .gyro_data, .irq_line_a, .irq_line_a_oe_n, .irq_line_b, .irq_line_b_oe_n,
    .sample_ready_pulse);
  imusf_host_model u_host (.link_clk, .reg_req, .reg_wr, .reg_addr, .reg_wdata,
    .reg_ack, .reg_rdata);
  // ==========
  // helpers
  task automatic chk(input logic [15:0] a, e);
    n_tests++;
    if (a !== e) begin
      n_fail++;
      $display("ERROR t=%0t got %h exp %h", $time, a, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    u_host.xfer(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a);
    u_host.xfer(1'b0, a, 8'h00, q);
  endtask
  function automatic logic [47:0] smp(input int i, input logic g);
    return {16'(i * 3 + 2), 16'(i * 3 + 1), 16'(i * 3)} ^ {48{g}};
  endfunction
  task automatic push(input int n);
    for (int i = 0; i < n; i++) begin
      @(negedge clock);
      accel_data = smp(n_smp, 1'b0);
      gyro_data = smp(n_smp, 1'b1);
      sample_strobe = 1'b1;
      n_smp++;
      @(negedge clock);
      sample_strobe = 1'b0;
    end
  endtask
  task automatic cnt_chk(input int w, input logic full);
    rd(ADDR_CNT);
    `CHK(q, w[7:0]);
    rd(ADDR_STATUS);
    `CHK({q[6], q[1:0]}, {full, w[9:8]});
  endtask
  task automatic pop_chk(input int i, input int nb);
    logic [95:0] v;
    v = {smp(i, 1'b1), smp(i, 1'b0)};
    for (int k = 0; k < nb; k++) begin
      rd(ADDR_POP);
      `CHK(q, v[8*k+:8]);
    end
  endtask
  // ==========
  // scenarios
  task automatic t_regs();
    wr(ADDR_WTM, 8'h5a);
    rd(ADDR_WTM);
    `CHK(q, 8'h5a);
    rd(8'h3c);
    `CHK(q, 8'h00);
    rd(ADDR_POP);
    `CHK(q, 8'h00);
  endtask
  task automatic t_sizes();
    int cap;
    wr(ADDR_SENS_EN, 8'h01);
    wr(ADDR_WTM, 8'h00);
    for (int c = 0; c < 4; c++) begin
      cap = 16 << c;
      wr(ADDR_FIFO_CTRL, 8'(c << CTRL_SIZE_LSB) | 8'(MODE_STOP));
      push(cap - 1);
      cnt_chk((cap - 1) * 3, 1'b0);
      push(2);
      cnt_chk(cap * 3, 1'b1);
      `CHK(q[7], 0);
      wr(ADDR_CMD, CMD_FLUSH);
      cnt_chk(0, 1'b0);
    end
  endtask
  task automatic t_drain();
    int b;
    wr(ADDR_INT_CFG, 8'h0c);
    wr(ADDR_WTM, 8'h04);
    wr(ADDR_FIFO_CTRL, 8'(MODE_STOP));
    b = n_smp;
    push(3);
    rd(ADDR_STATUS);
    `CHK({q[7], irq_line_a, irq_line_a_oe_n}, 3'b000);
    push(14);
    rd(ADDR_STATUS);
    `CHK(q[7:6], 2'b11);
    `CHK({irq_line_a, irq_line_a_oe_n, irq_line_b_oe_n}, 3'b101);
    cnt_chk(48, 1'b1);
    wr(ADDR_CMD, CMD_DRAIN);
    rd(ADDR_STATUS);
    `CHK(q[5], 1);
    push(1);
    for (int i = 0; i < 14; i++) pop_chk(b + i, 6);
    rd(ADDR_STATUS);
    `CHK({q[7], irq_line_a}, 2'b01);
    wr(ADDR_FIFO_CTRL, 8'(MODE_STOP));
    rd(ADDR_STATUS);
    `CHK({q[5], irq_line_a}, 2'b00);
    push(1);
    cnt_chk(9, 1'b0);
    wr(ADDR_CMD, CMD_DRAIN);
    pop_chk(b + 14, 6);
    pop_chk(b + 15, 6);
    pop_chk(b + 18, 6);
    wr(ADDR_FIFO_CTRL, 8'(MODE_STOP));
  endtask
  task automatic t_stream();
    int b;
    wr(ADDR_SENS_EN, 8'h03);
    wr(ADDR_INT_CFG, 8'h10);
    wr(ADDR_WTM, 8'h01);
    wr(ADDR_FIFO_CTRL, 8'(3 << CTRL_SIZE_LSB) | 8'(MODE_STREAM));
    b = n_smp;
    push(130);
    cnt_chk(768, 1'b1);
    `CHK({irq_line_b, irq_line_b_oe_n, irq_line_a_oe_n}, 3'b101);
    wr(ADDR_CMD, CMD_DRAIN);
    pop_chk(b + 2, 12);
    wr(ADDR_FIFO_CTRL, 8'(3 << CTRL_SIZE_LSB) | 8'(MODE_STREAM));
    wr(ADDR_CMD, CMD_FLUSH);
    cnt_chk(0, 1'b0);
    `CHK(irq_line_b, 0);
  endtask
  task automatic t_bypass();
    wr(ADDR_FIFO_CTRL, 8'(MODE_BYPASS));
    @(negedge clock);
    sample_strobe = 1'b1;
    @(negedge clock);
    sample_strobe = 1'b0;
    `CHK({sample_ready_pulse, irq_line_b}, 2'b11);
    @(negedge clock);
    `CHK({sample_ready_pulse, irq_line_b}, 2'b00);
    cnt_chk(0, 1'b0);
  endtask
  task automatic t_srst();
    wr(ADDR_FIFO_CTRL, 8'(MODE_STREAM));
    push(3);
    wr(ADDR_SRST, SRST_KEY);
    // soft reset lasts SRST_CYCLES clocks
    repeat (25) @(negedge clock);
    cnt_chk(0, 1'b0);
    rd(ADDR_WTM);
    `CHK(q, 8'h00);
    wr(ADDR_WTM, 8'h05);
    rd(ADDR_WTM);
    `CHK(q, 8'h05);
  endtask
  // ==========
  // run control
  task automatic end_sim();
    $display("checks %0d failures %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      end_sim();
    end
  end
  initial begin
    repeat (16) @(negedge clock);
    rst_n = 1'b1;
    repeat (5) @(negedge link_clk);
    `CHK({irq_line_a_oe_n, irq_line_b_oe_n, reg_busy}, 3'b110);
    t_regs();
    t_sizes();
    t_drain();
    t_stream();
    t_bypass();
    t_srst();
    `CHK(u_host.n_lost, 0);
    end_sim();
  end
endmodule
`default_nettype wire
